// [verilog/cbso_top.sv]
/*
 Upper half of the CardBus miscellaneous support register. Software
 writes fifteen override bits that drive the socket present-state bits.
 Assumes an Avalon-MM master with waitrequest on the same clock; the
 voltage-sense drive values come from the lower half on the same clock.
*/
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cbso_top
   import cbso_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic srst_in,
   // Avalon-MM slave
   input wire logic [31:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Lower-half sense drive values
   input wire logic voltage_sense_drive_first_in,
   input wire logic voltage_sense_drive_second_in,
   // Present-state drives
   output logic socket_volt_y_capable_out,
   output logic socket_volt_x_capable_out,
   output logic socket_3v3_capable_out,
   output logic socket_5v_capable_out,
   output logic card_volt_y_supported_out,
   output logic card_volt_x_supported_out,
   output logic card_3v3_supported_out,
   output logic card_5v_supported_out,
   output logic wrong_supply_attempt_out,
   output logic removed_while_active_out,
   output logic unsupported_card_out,
   output logic card_32bit_present_out,
   output logic card_16bit_present_out,
   output logic socket_powered_out,
   output logic card_detect_line_second_out,
   output logic card_detect_second_valid_out
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   cbso_bus_state_t state;
   logic hit;
   logic wr_take;
   logic [15:0] upper;
   logic [15:0] upper_wr;

   // Address decode
   assign hit = (avs_address_in == CBSO_MISC_SUPPORT_ADDR);
   assign wr_take = (state == CBSO_IDLE) && avs_write_in && hit;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then answer
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         state <= CBSO_IDLE;
      else
      begin
         unique case (state)
            CBSO_IDLE:
               if (avs_read_in || avs_write_in)
                  state <= CBSO_ANSWER;
            CBSO_ANSWER:
               state <= CBSO_IDLE;
            default:
               state <= CBSO_IDLE; // Unused codes fall back to idle
         endcase
      end
   end

   // Waitrequest low only in the answer cycle
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         avs_waitrequest_out <= 1'b1;
      else
         avs_waitrequest_out <= !((state == CBSO_IDLE) &&
                                  (avs_read_in || avs_write_in));
   end

   // Read data; lower half and unmapped read as zero
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         avs_readdata_out <= CBSO_UNMAPPED_DATA;
      else if ((state == CBSO_IDLE) && avs_read_in && hit)
         avs_readdata_out <= {upper & CBSO_UPPER_WMASK, 16'h0000};
      else
         avs_readdata_out <= CBSO_UNMAPPED_DATA;
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-bit override storage, byte lanes 2 and 3
   for (genvar i = 0; i < 16; i++)
   begin : g_bits
      assign upper_wr[i] = wr_take && avs_byteenable_in[2 + i / 8];
      cbso_field_reg #(
         .RESET_VAL(CBSO_UPPER_RESET[i]),
         .WRITABLE(CBSO_UPPER_WMASK[i])
      ) u_bit (
         .sys_clk_in(sys_clk_in),
         .srst_in(srst_in),
         .wr_en_in(upper_wr[i]),
         .wr_data_in(avs_writedata_in[16 + i]),
         .q_out(upper[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Present-state drives, one register per bit
   // Each drive follows its stored bit one edge later, so every output
   // leaves on a flip-flop; read-back sees the stored bit at once.
   // Software alone sets these values; nothing here filters them, so a
   // contradictory pattern (both card types, say) passes straight on.
   // The reserved bit 27 has no drive; its storage flop stays at zero.
   // All drives clear with the synchronous reset.

   ////////////////////////////////////////////////////////////////////////
   // Socket supply capability, bits 31 to 28

   // Socket accepts the Y.Y volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         socket_volt_y_capable_out <= 1'b0;
      else
         socket_volt_y_capable_out <= upper[CBSO_SKT_Y_POS - 16];
   end

   // Socket accepts the X.X volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         socket_volt_x_capable_out <= 1'b0;
      else
         socket_volt_x_capable_out <= upper[CBSO_SKT_X_POS - 16];
   end

   // Socket accepts the 3.3 volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         socket_3v3_capable_out <= 1'b0;
      else
         socket_3v3_capable_out <= upper[CBSO_SKT_3V3_POS - 16];
   end

   // Socket accepts the 5 volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         socket_5v_capable_out <= 1'b0;
      else
         socket_5v_capable_out <= upper[CBSO_SKT_5V_POS - 16];
   end

   ////////////////////////////////////////////////////////////////////////
   // Card supply support, bits 26 to 23

   // Card runs on the Y.Y volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_volt_y_supported_out <= 1'b0;
      else
         card_volt_y_supported_out <= upper[CBSO_CARD_Y_POS - 16];
   end

   // Card runs on the X.X volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_volt_x_supported_out <= 1'b0;
      else
         card_volt_x_supported_out <= upper[CBSO_CARD_X_POS - 16];
   end

   // Card runs on the 3.3 volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_3v3_supported_out <= 1'b0;
      else
         card_3v3_supported_out <= upper[CBSO_CARD_3V3_POS - 16];
   end

   // Card runs on the 5 volt supply
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_5v_supported_out <= 1'b0;
      else
         card_5v_supported_out <= upper[CBSO_CARD_5V_POS - 16];
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault flags, bits 22 and 21

   // Attempt at a wrong or unsupported supply
   // Held until software writes it back to zero
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         wrong_supply_attempt_out <= 1'b0;
      else
         wrong_supply_attempt_out <= upper[CBSO_BAD_VCC_POS - 16];
   end

   // Card pulled while the interface was active
   // Data may have been lost on the way out
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         removed_while_active_out <= 1'b0;
      else
         removed_while_active_out <= upper[CBSO_LOST_POS - 16];
   end

   ////////////////////////////////////////////////////////////////////////
   // Card type, bits 20 to 18

   // Unsupported card type in the socket
   // Software decides; no card probing here
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         unsupported_card_out <= 1'b0;
      else
         unsupported_card_out <= upper[CBSO_NOTA_POS - 16];
   end

   // 32-bit CardBus card in the socket
   // Not checked against the 16-bit flag
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_32bit_present_out <= 1'b0;
      else
         card_32bit_present_out <= upper[CBSO_CB_POS - 16];
   end

   // 16-bit PC card in the socket
   // Not checked against the 32-bit flag
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_16bit_present_out <= 1'b0;
      else
         card_16bit_present_out <= upper[CBSO_C16_POS - 16];
   end

   ////////////////////////////////////////////////////////////////////////
   // Socket power, bit 17

   // Socket power state
   // One powered up, zero powered down
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         socket_powered_out <= 1'b0;
      else
         socket_powered_out <= upper[CBSO_PWR_POS - 16];
   end

   ////////////////////////////////////////////////////////////////////////
   // Second card-detect, bit 16

   // Second card-detect level: zero inserted, one empty
   // Driven whatever the sense drives; validity leaves separately
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_detect_line_second_out <= 1'b0;
      else
         card_detect_line_second_out <= upper[CBSO_CD2_POS - 16];
   end

   ////////////////////////////////////////////////////////////////////////
   // Second card-detect qualifier
   cbso_valid_qual u_qual (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .voltage_sense_drive_first_in(voltage_sense_drive_first_in),
      .voltage_sense_drive_second_in(voltage_sense_drive_second_in),
      .card_detect_valid_out(card_detect_second_valid_out)
   );
endmodule : cbso_top

// [inc/cbso_pkg.sv]
/*
 Package for the CardBus socket state override block: register offset,
 field positions, reset values, unmapped read value and bus states.
 Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
package cbso_pkg;
   // Register byte address within the bridge register space
   localparam logic [31:0] CBSO_MISC_SUPPORT_ADDR = 32'hA030_004C;
   // Field positions of the upper half
   localparam int CBSO_SKT_Y_POS = 31;
   localparam int CBSO_SKT_X_POS = 30;
   localparam int CBSO_SKT_3V3_POS = 29;
   localparam int CBSO_SKT_5V_POS = 28;
   localparam int CBSO_RSVD_POS = 27;
   localparam int CBSO_CARD_Y_POS = 26;
   localparam int CBSO_CARD_X_POS = 25;
   localparam int CBSO_CARD_3V3_POS = 24;
   localparam int CBSO_CARD_5V_POS = 23;
   localparam int CBSO_BAD_VCC_POS = 22;
   localparam int CBSO_LOST_POS = 21;
   localparam int CBSO_NOTA_POS = 20;
   localparam int CBSO_CB_POS = 19;
   localparam int CBSO_C16_POS = 18;
   localparam int CBSO_PWR_POS = 17;
   localparam int CBSO_CD2_POS = 16;
   // Writable mask of the upper half (bit 27 hardwired zero)
   localparam logic [15:0] CBSO_UPPER_WMASK = 16'hF7FF;
   // Reset value of the upper half
   localparam logic [15:0] CBSO_UPPER_RESET = 16'h0000;
   // Value read from unmapped addresses
   localparam logic [31:0] CBSO_UNMAPPED_DATA = 32'h0000_0000;
   // Bus states
   typedef enum logic [1:0] {CBSO_IDLE, CBSO_ANSWER} cbso_bus_state_t;
endpackage : cbso_pkg

// [verilog/cbso_field_reg.sv]
/*
 One software-written field bit with byte-lane write strobe.
 Assumes a synchronous active-high reset on the single system clock.
*/
`timescale 1ns/1ps
module cbso_field_reg
   import cbso_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0,
   parameter logic WRITABLE = 1'b1
)(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic srst_in,
   // Write side
   input wire logic wr_en_in,
   input wire logic wr_data_in,
   // Stored value
   output logic q_out
);
   ////////////////////////////////////////////////////////////////////////
   // Storage; a hardwired bit ignores writes
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         q_out <= RESET_VAL;
      else if (wr_en_in && WRITABLE)
         q_out <= wr_data_in;
      else if (!WRITABLE)
         q_out <= 1'b0;
   end
endmodule : cbso_field_reg

// [verilog/cbso_valid_qual.sv]
/*
 Qualifies the second card-detect value by the voltage-sense drives.
 Assumes all inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module cbso_valid_qual
   import cbso_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic srst_in,
   // Sense drive values
   input wire logic voltage_sense_drive_first_in,
   input wire logic voltage_sense_drive_second_in,
   // Qualified indication
   output logic card_detect_valid_out
);
   ////////////////////////////////////////////////////////////////////////
   // Valid only with both sense drives low
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         card_detect_valid_out <= 1'b0;
      else
         card_detect_valid_out <= !voltage_sense_drive_first_in &&
                                  !voltage_sense_drive_second_in;
   end
endmodule : cbso_valid_qual

// [bench/cbso_top_checker.sv]
/*
 Checker for the socket state override block, bound to cbso_top.
 Assumes one clock and the synchronous reset of the top module.
*/
`timescale 1ns/1ps
module cbso_top_checker
   import cbso_pkg::*;
(
   // Clock, reset and bus
   input wire logic sys_clk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out,
   input wire logic [31:0] avs_address_in, avs_writedata_in, avs_readdata_out,
   input wire logic [3:0] avs_byteenable_in,
   // Sense drives and present-state drives
   input wire logic voltage_sense_drive_first_in, voltage_sense_drive_second_in,
   input wire logic socket_volt_y_capable_out, socket_volt_x_capable_out,
   input wire logic socket_3v3_capable_out, socket_5v_capable_out,
   input wire logic card_volt_y_supported_out, card_volt_x_supported_out,
   input wire logic card_3v3_supported_out, card_5v_supported_out,
   input wire logic wrong_supply_attempt_out, removed_while_active_out,
   input wire logic unsupported_card_out, card_32bit_present_out, card_16bit_present_out,
   input wire logic socket_powered_out, card_detect_line_second_out,
   input wire logic card_detect_second_valid_out
);
   // Upper half as seen on the drives, reserved bit zero
   wire logic [15:0] upper = {socket_volt_y_capable_out, socket_volt_x_capable_out,
      socket_3v3_capable_out, socket_5v_capable_out, 1'b0, card_volt_y_supported_out,
      card_volt_x_supported_out, card_3v3_supported_out, card_5v_supported_out,
      wrong_supply_attempt_out, removed_while_active_out, unsupported_card_out,
      card_32bit_present_out, card_16bit_present_out, socket_powered_out,
      card_detect_line_second_out};
   wire logic take = (avs_read_in | avs_write_in) & avs_waitrequest_out;
   wire logic hit = avs_address_in == CBSO_MISC_SUPPORT_ADDR;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   // One-cycle answer pulse
   sequence answer_s;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   wait_pulse_a: assert property (take |=> answer_s) else $error("bad answer pulse");
   read_data_a: assert property (take && avs_read_in && hit
      |=> avs_readdata_out == {$past(upper), 16'h0000}) else $error("read data wrong");
   unmapped_read_a: assert property (take && avs_read_in && !hit
      |=> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
   top_bit_a: assert property (take && avs_write_in && hit && avs_byteenable_in[3]
      |-> ##2 socket_volt_y_capable_out == $past(avs_writedata_in[31], 2))
      else $error("bit 31 not driven");
   detect_bit_a: assert property (take && avs_write_in && hit && avs_byteenable_in[2]
      |-> ##2 card_detect_line_second_out == $past(avs_writedata_in[16], 2))
      else $error("bit 16 not driven");
   keep_value_a: assert property (take && avs_write_in && !(hit && avs_byteenable_in[3])
      |-> ##2 socket_5v_capable_out == $past(socket_5v_capable_out, 2))
      else $error("bit 28 changed");
   sense_valid_a: assert property (!$past(srst_in) |-> card_detect_second_valid_out ==
      $past(!voltage_sense_drive_first_in && !voltage_sense_drive_second_in))
      else $error("detect validity wrong");
   reset_clear_a: assert property ($fell(srst_in) |-> avs_waitrequest_out &&
      upper == 16'h0000 && !card_detect_second_valid_out) else $error("reset state wrong");
endmodule : cbso_top_checker

bind cbso_top cbso_top_checker chk (.*);

// [bench/cbso_top_tb.sv]
/*
 Bench for cbso_top: random Avalon-MM writes and reads against a model.
 Assumes the checker file is compiled before it.
*/
`timescale 1ns/1ps
module cbso_top_tb
   import cbso_pkg::*;
;
   logic sys_clk_in = 0, srst_in = 1, avs_read_in = 0, avs_write_in = 0;
   logic [31:0] avs_address_in = 0, avs_writedata_in = 0, avs_readdata_out, rd, a, d;
   logic [3:0] avs_byteenable_in = 0, be;
   logic voltage_sense_drive_first_in = 0, voltage_sense_drive_second_in = 0;
   wire logic [15:0] o;
   logic [15:0] model;
   assign o[11] = 1'b0; // Reserved bit 27 has no drive
   logic avs_waitrequest_out, vld;
   int n_mismatch = 0, samples_checked = 0, seed = 32'h5ead;
   cbso_top dut (.*, .socket_volt_y_capable_out(o[15]), .socket_volt_x_capable_out(o[14]),
      .socket_3v3_capable_out(o[13]), .socket_5v_capable_out(o[12]),
      .card_volt_y_supported_out(o[10]), .card_volt_x_supported_out(o[9]),
      .card_3v3_supported_out(o[8]), .card_5v_supported_out(o[7]),
      .wrong_supply_attempt_out(o[6]), .removed_while_active_out(o[5]),
      .unsupported_card_out(o[4]), .card_32bit_present_out(o[3]),
      .card_16bit_present_out(o[2]), .socket_powered_out(o[1]),
      .card_detect_line_second_out(o[0]), .card_detect_second_valid_out(vld));
   ////////////////////////////////////////////////
   // Clock
   initial forever #2.5 sys_clk_in = ~sys_clk_in;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] wd,
      input logic [3:0] en);
      @(posedge sys_clk_in);
      avs_write_in <= wr;
      avs_read_in <= !wr;
      avs_address_in <= ad;
      avs_writedata_in <= wd;
      avs_byteenable_in <= en;
      do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask : bus
   // Drives, validity and read-back against the model
   task automatic outs();
      #1;
      chk(o[15:12], model[15:12]);
      chk(o[10:7], model[10:7]);
      chk(o[6], model[6]);
      chk(o[5], model[5]);
      chk(o[4], model[4]);
      chk(o[3], model[3]);
      chk(o[2], model[2]);
      chk(o[1], model[1]);
      chk(o[0], model[0]);
      chk(vld, !(voltage_sense_drive_first_in | voltage_sense_drive_second_in));
      bus(1'b0, CBSO_MISC_SUPPORT_ADDR, 32'h0000_0000, 4'hF);
      chk(rd, {model, 16'h0000});
   endtask : outs
   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // Watchdog
   initial
   begin
      repeat (5000) @(posedge sys_clk_in);
      n_mismatch++;
      end_of_test();
   end
   // Main sequence: reset, saturating write, random traffic, second reset
   initial
   begin
      model = 16'h0000;
      repeat (3) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      @(posedge sys_clk_in);
      outs();
      for (int i = 0; i < 62; i++)
      begin
         a = ($random(seed) & 3) != 0 ? CBSO_MISC_SUPPORT_ADDR : $random(seed);
         d = (i == 0 || i == 61) ? 32'hFFFF_FFFF : $random(seed);
         be = (i == 0 || i == 61) ? 4'hF : 4'($random(seed));
         a = (i == 0 || i == 61) ? CBSO_MISC_SUPPORT_ADDR : a;
         {voltage_sense_drive_first_in, voltage_sense_drive_second_in} <= 2'($random(seed));
         bus(1'b1, a, d, be);
         if (a == CBSO_MISC_SUPPORT_ADDR)
         begin
            model[15:8] = be[3] ? d[31:24] : model[15:8];
            model[7:0] = be[2] ? d[23:16] : model[7:0];
            model = model & 16'hF7FF;
         end
         else
         begin
            bus(1'b0, a, 32'h0000_0000, 4'hF);
            chk(rd, 32'h0000_0000);
         end
         outs();
      end
      srst_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      model = 16'h0000;
      @(posedge sys_clk_in);
      outs();
      end_of_test();
   end
endmodule : cbso_top_tb
